// File: eic_defines.vh
// Constants of the instruction engine: offsets, bits, codes and counts
`ifndef EIC_DEFINES_VH
`define EIC_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define EIC_OFF_CTRL 8'h00
`define EIC_OFF_STAT 8'h04
`define EIC_OFF_SEQ0 8'h08
`define EIC_OFF_SEQ3 8'h14

// ----------------------------------------------------------------
// Control and status bit positions
// ----------------------------------------------------------------
`define EIC_CTL_LOAD 0
`define EIC_CTL_SAVE 1
`define EIC_CTL_VFY 2
`define EIC_CTL_WREN 3
`define EIC_CTL_CID_LO 4
`define EIC_CTL_CID_HI 7
`define EIC_ST_LOAD 0
`define EIC_ST_SAVE 1
`define EIC_ST_CRC 2
`define EIC_ST_FAULT 3
`define EIC_ST_PAUSE 4

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define EIC_OP_IOUPD 8'h80
`define EIC_OP_CAL_ALL 8'h90
`define EIC_OP_CAL_SYS 8'h91
`define EIC_OP_CAL_A0 8'h92
`define EIC_OP_CAL_A1 8'h93
`define EIC_OP_FR_ALL 8'h98
`define EIC_OP_FR_D0 8'h99
`define EIC_OP_FR_D1 8'h9A
`define EIC_OP_SYN_ALL 8'hA0
`define EIC_OP_SYN_C0 8'hA1
`define EIC_OP_SYN_C1 8'hA2
`define EIC_OP_COND 4'hB
`define EIC_OP_PAUSE 8'hFE
`define EIC_OP_END 8'hFF

// ----------------------------------------------------------------
// Checksum and counts
// ----------------------------------------------------------------
`define EIC_CRC_POLY 32'hEDB8_8320
`define EIC_CRC_INIT 32'hFFFF_FFFF
`define EIC_HDR_LAST 3'h5
`define EIC_CRC_LAST 3'h3
`define EIC_SEQ_END 4'hF

`endif

// File: eic_engine.v
// Instruction engine of the serial configuration memory controller
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "eic_defines.vh"
module eic_engine (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [15:0] id_vendor,
    input wire [7:0] id_chip_type,
    input wire [15:0] id_product,
    input wire [7:0] id_revision,
    output reg mem_req,
    output reg mem_write,
    output reg [15:0] mem_addr,
    output reg [7:0] mem_wdata,
    input wire mem_ack,
    input wire [7:0] mem_rdata,
    output reg [15:0] reg_addr,
    output reg [7:0] reg_wdata,
    output reg reg_we,
    input wire [7:0] reg_rdata,
    output reg io_update,
    output reg cal_sys_loop,
    output reg cal_first_analog_output_loop,
    output reg cal_second_analog_output_loop,
    output reg freerun_first_digital_tracking_loop,
    output reg freerun_second_digital_tracking_loop,
    output reg sync_channel0,
    output reg sync_channel1
);

    // ------------------------------------------------------------
    // States and phases
    // ------------------------------------------------------------
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_GET = 5'b00010;
    localparam [4:0] S_MEM = 5'b00100;
    localparam [4:0] S_DROP = 5'b01000;
    localparam [4:0] S_EXEC = 5'b10000;
    localparam [5:0] P_HDR = 6'b000001;
    localparam [5:0] P_OP = 6'b000010;
    localparam [5:0] P_AHI = 6'b000100;
    localparam [5:0] P_ALO = 6'b001000;
    localparam [5:0] P_DAT = 6'b010000;
    localparam [5:0] P_CRC = 6'b100000;

    reg [4:0] st;
    reg [5:0] ph;
    reg upl, vfy, load_busy, save_busy, paused, crc_err, fault, wren;
    reg ack_s1, ack_s2;
    reg [3:0] cid, sidx;
    reg [2:0] idx;
    reg [7:0] cnt, wbyte, rbyte, hdr_b, src_b;
    reg [15:0] ptr, raddr, cmap;
    reg [31:0] crc, rx;
    reg [7:0] seq [0:15];
    wire [31:0] crc_out = ~crc;
    wire [31:0] rx_full;
    wire [31:0] next_crc;
    wire [7:0] b;
    wire run;

    // Byte update of the reflected checksum
    function [31:0] eic_crc8;
        input [31:0] c;
        input [7:0] d;
        integer i;
        reg [31:0] t;
        begin
            t = c ^ {24'h00_0000, d};
            for (i = 0; i < 8; i = i + 1) begin
                t = t[0] ? ((t >> 1) ^ `EIC_CRC_POLY) : (t >> 1);
            end
            eic_crc8 = t;
        end
    endfunction

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire hit = (paddr[1:0] == 2'b00) && (paddr <= `EIC_OFF_SEQ3);
    wire wr_ctl = wr & (paddr == `EIC_OFF_CTRL) & pstrb[0];
    wire wr_st = wr & (paddr == `EIC_OFF_STAT) & pstrb[0];
    wire go_load = wr_ctl & pwdata[`EIC_CTL_LOAD];
    wire go_save = wr_ctl & pwdata[`EIC_CTL_SAVE];
    wire go_vfy = wr_ctl & pwdata[`EIC_CTL_VFY];
    wire clr_crc = wr_st & pwdata[`EIC_ST_CRC];
    wire clr_flt = wr_st & pwdata[`EIC_ST_FAULT];
    wire [7:0] wsub = {2'b00, paddr[7:2]} - (`EIC_OFF_SEQ0 >> 2); // Word index within the bytes
    wire [5:0] widx = wsub[5:0];
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;

    // Stored control fields and read data latched in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wren <= 1'b0;
            cid <= 4'h0;
            prdata <= 32'h0000_0000;
        end else begin
            if (wr_ctl) begin
                wren <= pwdata[`EIC_CTL_WREN];
                cid <= pwdata[`EIC_CTL_CID_HI:`EIC_CTL_CID_LO];
            end
            if (psel & ~penable) begin
                prdata <= 32'h0000_0000;
                if (paddr == `EIC_OFF_CTRL) begin
                    prdata <= {24'h00_0000, cid, wren, 3'b000};
                end else if (paddr == `EIC_OFF_STAT) begin
                    prdata <= {27'h000_0000, paused, fault, crc_err, save_busy, load_busy};
                end else if (hit) begin
                    prdata <= {seq[{widx[1:0], 2'd3}], seq[{widx[1:0], 2'd2}],
                               seq[{widx[1:0], 2'd1}], seq[{widx[1:0], 2'd0}]};
                end
            end
        end
    end

    // Sequence bytes, one lane each
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_seq
            localparam [31:0] WSUM = `EIC_OFF_SEQ0 + (g / 4) * 4;
            localparam [7:0] WADDR = WSUM[7:0];
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    seq[g] <= 8'h00;
                end else if (wr && paddr == WADDR && pstrb[g % 4]) begin
                    seq[g] <= pwdata[(g % 4) * 8 +: 8];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Byte sources and decode helpers
    // ------------------------------------------------------------
    assign b = upl ? wbyte : rbyte;
    assign next_crc = eic_crc8(crc, b);
    assign rx_full = {b, rx[31:8]};
    assign run = (cid == 4'h0) || (cmap == 16'h0000) || cmap[cid];

    // Header byte and upload source selection
    always @* begin
        case (idx)
            3'h0: hdr_b = id_vendor[15:8];
            3'h1: hdr_b = id_vendor[7:0];
            3'h2: hdr_b = id_chip_type;
            3'h3: hdr_b = id_product[15:8];
            3'h4: hdr_b = id_product[7:0];
            default: hdr_b = id_revision;
        endcase
        case (ph)
            P_HDR: src_b = hdr_b;
            P_DAT: src_b = reg_rdata;
            P_CRC: src_b = crc_out[{idx[1:0], 3'b000} +: 8];
            default: src_b = seq[sidx];
        endcase
    end

    // Acknowledge from the memory clock domain
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= mem_ack;
            ack_s2 <= ack_s1;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= S_IDLE;
            ph <= P_HDR;
            upl <= 1'b0;
            vfy <= 1'b0;
            load_busy <= 1'b0;
            save_busy <= 1'b0;
            paused <= 1'b0;
            crc_err <= 1'b0;
            fault <= 1'b0;
            sidx <= 4'h0;
            idx <= 3'h0;
            cnt <= 8'h00;
            wbyte <= 8'h00;
            rbyte <= 8'h00;
            ptr <= 16'h0000;
            raddr <= 16'h0000;
            cmap <= 16'h0000;
            crc <= `EIC_CRC_INIT;
            rx <= 32'h0000_0000;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            reg_addr <= 16'h0000;
            reg_wdata <= 8'h00;
            reg_we <= 1'b0;
            io_update <= 1'b0;
            cal_sys_loop <= 1'b0;
            cal_first_analog_output_loop <= 1'b0;
            cal_second_analog_output_loop <= 1'b0;
            freerun_first_digital_tracking_loop <= 1'b0;
            freerun_second_digital_tracking_loop <= 1'b0;
            sync_channel0 <= 1'b0;
            sync_channel1 <= 1'b0;
        end else begin
            reg_we <= 1'b0;
            io_update <= 1'b0;
            cal_sys_loop <= 1'b0;
            cal_first_analog_output_loop <= 1'b0;
            cal_second_analog_output_loop <= 1'b0;
            freerun_first_digital_tracking_loop <= 1'b0;
            freerun_second_digital_tracking_loop <= 1'b0;
            sync_channel0 <= 1'b0;
            sync_channel1 <= 1'b0;
            // Software clears first so a same-cycle set wins
            if (clr_crc) crc_err <= 1'b0;
            if (clr_flt) fault <= 1'b0;
            case (st)
                S_IDLE: begin
                    if (go_load | go_vfy) begin
                        upl <= 1'b0;
                        vfy <= go_vfy & ~go_load;
                        load_busy <= 1'b1;
                        paused <= 1'b0;
                        ptr <= 16'h0000;
                        crc <= `EIC_CRC_INIT;
                        ph <= P_HDR;
                        idx <= 3'h0;
                        cmap <= 16'h0000;
                        st <= S_GET;
                    end else if (go_save) begin
                        if (!wren) begin
                            fault <= 1'b1;
                        end else begin
                            upl <= 1'b1;
                            save_busy <= 1'b1;
                            sidx <= 4'h0;
                            paused <= 1'b0;
                            st <= S_GET;
                            if (paused) begin
                                ph <= P_OP;
                            end else begin
                                ptr <= 16'h0000;
                                crc <= `EIC_CRC_INIT;
                                ph <= P_HDR;
                                idx <= 3'h0;
                            end
                        end
                    end
                end
                S_GET: begin
                    if (upl && (ph == P_OP || ph == P_AHI || ph == P_ALO) &&
                        (sidx == `EIC_SEQ_END ||
                         (ph == P_OP && seq[sidx] == `EIC_OP_PAUSE))) begin
                        save_busy <= 1'b0;
                        paused <= 1'b1;
                        st <= S_IDLE;
                    end else begin
                        wbyte <= src_b;
                        mem_req <= 1'b1;
                        mem_write <= upl;
                        mem_wdata <= src_b;
                        mem_addr <= ptr;
                        st <= S_MEM;
                    end
                end
                S_MEM: begin
                    if (ack_s2) begin
                        mem_req <= 1'b0;
                        rbyte <= mem_rdata;
                        st <= S_DROP;
                    end
                end
                S_DROP: begin
                    if (!ack_s2) st <= S_EXEC;
                end
                S_EXEC: begin
                    st <= S_GET;
                    ptr <= ptr + 16'h0001;
                    if (ph != P_CRC) crc <= next_crc;
                    case (ph)
                        P_HDR: begin
                            if (!upl && b != hdr_b) begin
                                fault <= 1'b1;
                                load_busy <= 1'b0;
                                ptr <= 16'h0000;
                                st <= S_IDLE;
                            end else if (idx == `EIC_HDR_LAST) begin
                                idx <= 3'h0;
                                ph <= P_OP;
                            end else begin
                                idx <= idx + 3'h1;
                            end
                        end
                        P_OP: begin
                            if (upl) sidx <= sidx + 4'h1;
                            if (!b[7]) begin
                                cnt <= {1'b0, b[6:0]} + 8'h01;
                                ph <= P_AHI;
                            end else if (b == `EIC_OP_END) begin
                                idx <= 3'h0;
                                ph <= P_CRC;
                            end else if (!upl && b[7:4] == `EIC_OP_COND) begin
                                if (b[3:0] == 4'h0) begin
                                    cmap <= 16'h0000;
                                end else begin
                                    cmap[b[3:0]] <= 1'b1;
                                end
                            end else if (!upl && run && !vfy) begin
                                // Actions; undefined codes fall through
                                case (b)
                                    `EIC_OP_IOUPD: io_update <= 1'b1;
                                    `EIC_OP_CAL_ALL: begin
                                        cal_sys_loop <= 1'b1;
                                        cal_first_analog_output_loop <= 1'b1;
                                        cal_second_analog_output_loop <= 1'b1;
                                    end
                                    `EIC_OP_CAL_SYS: cal_sys_loop <= 1'b1;
                                    `EIC_OP_CAL_A0: cal_first_analog_output_loop <= 1'b1;
                                    `EIC_OP_CAL_A1: cal_second_analog_output_loop <= 1'b1;
                                    `EIC_OP_FR_ALL: begin
                                        freerun_first_digital_tracking_loop <= 1'b1;
                                        freerun_second_digital_tracking_loop <= 1'b1;
                                    end
                                    `EIC_OP_FR_D0: freerun_first_digital_tracking_loop <= 1'b1;
                                    `EIC_OP_FR_D1: freerun_second_digital_tracking_loop <= 1'b1;
                                    `EIC_OP_SYN_ALL: begin
                                        sync_channel0 <= 1'b1;
                                        sync_channel1 <= 1'b1;
                                    end
                                    `EIC_OP_SYN_C0: sync_channel0 <= 1'b1;
                                    `EIC_OP_SYN_C1: sync_channel1 <= 1'b1;
                                    default: io_update <= 1'b0;
                                endcase
                            end
                        end
                        P_AHI: begin
                            if (upl) sidx <= sidx + 4'h1;
                            raddr[15:8] <= b;
                            ph <= P_ALO;
                        end
                        P_ALO: begin
                            if (upl) sidx <= sidx + 4'h1;
                            raddr[7:0] <= b;
                            reg_addr <= {raddr[15:8], b};
                            ph <= P_DAT;
                        end
                        P_DAT: begin
                            if (!upl && run && !vfy) begin
                                reg_we <= 1'b1;
                                reg_wdata <= b;
                            end
                            reg_addr <= upl ? raddr + 16'h0001 : raddr;
                            raddr <= raddr + 16'h0001;
                            cnt <= cnt - 8'h01;
                            if (cnt == 8'h01) ph <= P_OP;
                        end
                        default: begin
                            rx <= rx_full;
                            if (idx == `EIC_CRC_LAST) begin
                                ptr <= 16'h0000;
                                st <= S_IDLE;
                                save_busy <= 1'b0;
                                load_busy <= 1'b0;
                                if (!upl && rx_full != crc_out) begin
                                    crc_err <= 1'b1;
                                end
                            end else begin
                                idx <= idx + 3'h1;
                            end
                        end
                    endcase
                end
                default: st <= S_IDLE;
            endcase
        end
    end

endmodule // eic_engine

// File: eic_asserts.sv
// Checker for the memory link, register port and action pulses of the engine
`timescale 1ns/1ps
module eic_asserts (
    input wire pclk,
    input wire presetn,
    input wire mem_req,
    input wire mem_write,
    input wire [15:0] mem_addr,
    input wire [7:0] mem_wdata,
    input wire mem_ack,
    input wire [15:0] id_vendor,
    input wire [7:0] id_revision,
    input wire reg_we,
    input wire io_update,
    input wire cal_sys_loop,
    input wire sync_channel0,
    input wire sync_channel1
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [3:0] acts = {io_update, cal_sys_loop, sync_channel0, sync_channel1};
    reg req_d;
    reg [15:0] last_a;
    // Remember the address of the previous memory request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_d <= 1'b0;
            last_a <= 16'h0000;
        end else begin
            req_d <= mem_req;
            if (mem_req && !req_d)
                last_a <= mem_addr;
        end
    end
    a_req_hold: assert property ($past(mem_req) && mem_req
        |-> $stable({mem_addr, mem_write, mem_wdata})) else $error("request changed early");
    a_addr_step: assert property (mem_req && !req_d && mem_addr != 16'h0000
        |-> mem_addr == last_a + 16'h0001) else $error("memory address skipped");
    a_req_drop: assert property ($fell(mem_req)
        |-> $past(mem_ack, 2) && $past(mem_ack)) else $error("request dropped before ack");
    a_hdr_vendor: assert property (mem_req && !req_d && mem_write && mem_addr == 16'h0000
        |-> mem_wdata == id_vendor[15:8]) else $error("header vendor byte wrong");
    a_hdr_rev: assert property (mem_req && !req_d && mem_write && mem_addr == 16'h0005
        |-> mem_wdata == id_revision) else $error("header revision byte wrong");
    a_we_pulse: assert property (reg_we |=> !reg_we) else $error("register write too long");
    a_act_pulse: assert property (|acts |=> !(|acts)) else $error("action pulse too long");
    a_act_read: assert property (reg_we || |acts
        |-> !mem_write) else $error("action during upload");
endmodule // eic_asserts
bind eic_engine eic_asserts u_chk (.pclk, .presetn, .mem_req, .mem_write, .mem_addr,
    .mem_wdata, .mem_ack, .id_vendor, .id_revision, .reg_we, .io_update, .cal_sys_loop,
    .sync_channel0, .sync_channel1);

// File: eic_mem_model.sv
// Serial configuration memory behind the four-phase byte handshake
`timescale 1ns/1ps
module eic_mem_model (
    input wire lclk,
    input wire mem_req,
    input wire mem_write,
    input wire [15:0] mem_addr,
    input wire [7:0] mem_wdata,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:63];
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
    end
    // Serve one byte per request; data turns over once acknowledge drops
    always @(posedge lclk) begin
        if (mem_req && !mem_ack) begin
            if (mem_write)
                mem[mem_addr[5:0]] <= mem_wdata;
            mem_rdata <= mem[mem_addr[5:0]];
            mem_ack <= 1'b1;
        end else if (!mem_req && mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // eic_mem_model

// File: tb_top.sv
// Bench: upload, download, verify checksum error, header fault and conditional skip
`timescale 1ns/1ps
`include "eic_defines.vh"
module tb_top;
    logic pclk, presetn, lclk, psel, penable, pwrite, err;
    logic [7:0] paddr, id_chip_type, id_revision;
    logic [31:0] pwdata, rd, c;
    logic [15:0] id_vendor, id_product;
    wire pready, pslverr, mem_req, mem_write, mem_ack, reg_we;
    wire [31:0] prdata;
    wire [15:0] mem_addr, reg_addr;
    wire [7:0] mem_wdata, mem_rdata, reg_wdata, acts;
    logic [7:0] regs [0:255];
    logic [7:0] ex [0:19];
    int pc [0:7];
    int fail_count, n_checks, nwe, cyc;
    eic_engine dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
        .prdata, .pready, .pslverr, .id_vendor, .id_chip_type, .id_product, .id_revision,
        .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .reg_addr,
        .reg_wdata, .reg_we, .reg_rdata(reg_addr[7:0] ^ 8'h5A), .io_update(acts[0]),
        .cal_sys_loop(acts[1]), .cal_first_analog_output_loop(acts[2]),
        .cal_second_analog_output_loop(acts[3]), .freerun_first_digital_tracking_loop(acts[4]),
        .freerun_second_digital_tracking_loop(acts[5]), .sync_channel0(acts[6]),
        .sync_channel1(acts[7]));
    eic_mem_model mdl (.lclk, .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    // Bus clock and an unrelated memory clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        lclk = 1'b0;
        #7.3;
        forever #62.5 lclk = ~lclk;
    end
    // Record register writes, count action pulses, cut a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (reg_we) begin
            regs[reg_addr[7:0]] <= reg_wdata;
            nwe <= nwe + 1;
        end
        for (int i = 0; i < 8; i++)
            if (acts[i])
                pc[i] <= pc[i] + 1;
        if (cyc == 40000) begin
            fail_count++;
            wrap_up();
        end
    end
    function automatic logic [31:0] crc8(input logic [31:0] s, input logic [7:0] b);
        s = s ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++)
            s = s[0] ? (s >> 1) ^ 32'hEDB8_8320 : s >> 1;
        return s;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Start an operation and poll status until both busy bits clear
    task automatic run(input logic [31:0] ctl, input logic busy);
        apb(1'b1, `EIC_OFF_CTRL, ctl);
        apb(1'b0, `EIC_OFF_STAT, 32'h0000_0000);
        chk(rd[0], busy);
        do begin
            apb(1'b0, `EIC_OFF_STAT, 32'h0000_0000);
        end while (rd[1:0] !== 2'b00);
    endtask
    // Register writes and action pulses seen so far
    task automatic side(input logic [7:0] ep);
        chk({8'h00, regs[8'h10], regs[8'h11], nwe[7:0]}, 32'h004A_4B02);
        for (int i = 0; i < 8; i++)
            chk(pc[i], {24'h00_0000, ep[i]});
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        id_vendor = 16'h1234; // Identity values are arbitrary
        id_chip_type = 8'h56;
        id_product = 16'h789A;
        id_revision = 8'hBC;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b1, `EIC_OFF_SEQ0, 32'h8010_0001);
        apb(1'b1, 8'h0C, 32'hFFA1_8591);
        apb(1'b1, `EIC_OFF_CTRL, 32'h0000_0008);
        run(32'h0000_000A, 1'b0);
        chk(rd, 32'h0000_0000);
        ex = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'h01, 8'h00, 8'h10, 8'h4A, 8'h4B,
            8'h80, 8'h91, 8'h85, 8'hA1, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
        c = 32'hFFFF_FFFF;
        for (int i = 0; i < 16; i++)
            c = crc8(c, ex[i]);
        c = ~c;
        for (int i = 0; i < 4; i++)
            ex[16 + i] = c[8 * i +: 8];
        for (int i = 0; i < 20; i++)
            chk(mdl.mem[i], ex[i]);
        run(32'h0000_0009, 1'b1);
        chk(rd, 32'h0000_0000);
        side(8'h43);
        mdl.mem[10] = 8'h00;
        run(32'h0000_000C, 1'b1);
        chk(rd, 32'h0000_0004);
        side(8'h43);
        mdl.mem[10] = 8'h4B;
        apb(1'b1, `EIC_OFF_STAT, 32'h0000_0004);
        id_revision <= 8'hBD;
        run(32'h0000_0009, 1'b1);
        chk(rd, 32'h0000_0008);
        side(8'h43);
        id_revision <= 8'hBC;
        apb(1'b1, `EIC_OFF_STAT, 32'h0000_0008);
        apb(1'b1, `EIC_OFF_SEQ0, 32'h91B0_80B1);
        apb(1'b1, 8'h0C, 32'h0000_00FF);
        run(32'h0000_000A, 1'b0);
        run(32'h0000_0029, 1'b1);
        chk(rd, 32'h0000_0000);
        chk({pc[0][7:0], pc[1][7:0]}, 16'h0102);
        // Every defined action code but 80, 91 and A1 once more, stored then replayed
        apb(1'b1, `EIC_OFF_SEQ0, 32'h9893_9290);
        apb(1'b1, 8'h0C, 32'hA2A0_9A99);
        apb(1'b1, 8'h10, 32'h0000_00FF);
        run(32'h0000_000A, 1'b0);
        chk(mdl.mem[6], 8'h90);
        run(32'h0000_0009, 1'b1);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 8; i++)
            c[4 * i +: 4] = pc[i][3:0];
        chk(c, 32'h2222_2231);
        wrap_up();
    end
endmodule // tb_top
